// file: design/arpwm_pkg.sv
// constants shared by the auto-reload pwm timer register block
package arpwm_pkg;

   // ----------------------------------------------------------------
   // register byte offsets on the avalon-mm slave
   // ----------------------------------------------------------------
   localparam logic [5:0] OFF_TIMER_CTRL = 6'h00;
   localparam logic [5:0] OFF_COUNT_HI = 6'h04;
   localparam logic [5:0] OFF_COUNT_LO = 6'h08;
   localparam logic [5:0] OFF_RELOAD_HI = 6'h0C;
   localparam logic [5:0] OFF_RELOAD_LO = 6'h10;
   localparam logic [5:0] OFF_PWM_OUT_CTRL = 6'h14;
   localparam logic [5:0] OFF_CHAN_BASE = 6'h18;
   localparam logic [5:0] OFF_CHAN_STRIDE = 6'h04;
   localparam logic [5:0] OFF_BREAK_CTRL = 6'h28;
   localparam logic [5:0] OFF_CAPTURE_HI = 6'h2C;
   localparam logic [5:0] OFF_CAPTURE_LO = 6'h30;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int TC_CAPTURE_FLAG = 6;
   localparam int TC_CAPTURE_IE = 5;
   localparam int TC_SOURCE_HI = 4;
   localparam int TC_SOURCE_LO = 3;
   localparam int TC_OVERFLOW_FLAG = 2;
   localparam int TC_OVERFLOW_IE = 1;
   localparam int TC_COMPARE_IE = 0;
   localparam int CH_ONE_PULSE_EN = 3;
   localparam int CH_ONE_PULSE_EDGE = 2;
   localparam int CH_INVERT = 1;
   localparam int CH_COMPARE_FLAG = 0;
   localparam int BK_SOURCE_SEL = 7;
   localparam int BK_LEVEL_SEL = 6;
   localparam int BK_ACTIVE = 5;
   localparam int BK_PIN_ENABLE = 4;

   // ----------------------------------------------------------------
   // counter source encodings, limits and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_LITE = 2'h1;
   localparam logic [1:0] SRC_CPU = 2'h2;
   localparam logic [11:0] COUNT_TOP = 12'hFFF;
   localparam logic [11:0] COUNT_RESET = 12'h000;
   localparam logic [7:0] REG_RESET = 8'h00;

endpackage : arpwm_pkg

// file: design/arpwm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module arpwm_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // asynchronous in, filtered level out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] agree;

   // only stage2 and stage3 are compared; stage1 may be metastable
   assign agree = ~(stage2_q ^ stage3_q);

   // shift chain
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end
      else
      begin
         stage1_q <= i_async;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // a change counts once the last two stages agree
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         level_q <= '0;
      else
         level_q <= (agree & stage3_q) | (~agree & level_q);
   end

   assign o_level = level_q;

endmodule : arpwm_sync
`default_nettype wire

// file: design/arpwm_timer.sv
// auto-reload 12-bit pwm timer with avalon-mm register access
//
// What this block does
// - capture sets flag; capture-value read clears it
// - capture enable gates capture interrupt request
// - source field: off, lite tick, cpu clock
// - overflow sets flag; control register read clears
// - overflow enable bit gates overflow interrupt
// - compare enable masks any-channel compare interrupt
// - twelve-bit up-counter, read as two bytes
// - overflow restarts counter from reload value
// - writable reload register loaded at overflow
// - one output enable per channel, even bits
// - channel three bit 3 enables one-pulse
// - channel three bit 2 picks trigger edge
// - per-channel invert bit flips the pwm output
// - compare flag on match; channel read clears
// - break active set by pin at level
// - break pattern forces enabled outputs
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module arpwm_timer (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // time base and active duty values from neighbouring logic
   input wire logic i_lite_tick,
   input wire logic [11:0] i_duty_value0,
   input wire logic [11:0] i_duty_value1,
   input wire logic [11:0] i_duty_value2,
   input wire logic [11:0] i_duty_value3,
   // pins
   input wire logic i_capture_pin,
   input wire logic i_lite_capture_pin,
   input wire logic i_break_pin,
   input wire logic i_comparator,
   // pwm outputs and interrupt requests
   output logic [3:0] o_pwm,
   output logic [3:0] o_pwm_enable,
   output logic o_capture_irq,
   output logic o_overflow_irq,
   output logic o_compare_irq
);

   // ----------------------------------------------------------------
   // decode helper
   // ----------------------------------------------------------------
   function automatic logic is_chan(input logic [5:0] addr, input int idx);
      logic [5:0] off;
      off = arpwm_pkg::OFF_CHAN_BASE + 6'(idx) * arpwm_pkg::OFF_CHAN_STRIDE;
      return addr == off;
   endfunction : is_chan

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic wait_q;
   logic [31:0] readdata_q;
   logic [11:0] counter_q;
   logic [11:0] counter_d;
   logic [11:0] reload_q;
   logic [11:0] capture_q;
   logic capture_flag_q;
   logic capture_irq_enable_q;
   logic [1:0] counter_source_sel_q;
   logic overflow_flag_one_q;
   logic overflow_irq_enable_one_q;
   logic compare_irq_enable_q;
   logic [3:0] output_enable_q;
   logic [3:0] channel_invert_q;
   logic [3:0] compare_flag_q;
   logic [3:0] level_q;
   logic one_pulse_enable_q;
   logic one_pulse_trigger_edge_q;
   logic break1_source_sel_q;
   logic break1_level_sel_q;
   logic break1_active_q;
   logic break1_pin_enable_q;
   logic [3:0] break_pattern_q;
   logic cap_prev_q;
   logic lcap_prev_q;
   logic [3:0] pwm_q;
   logic [3:0] pwm_enable_q;
   logic capture_irq_q;
   logic overflow_irq_q;
   logic compare_irq_q;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pins_s;

   arpwm_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async({i_comparator, i_break_pin, i_lite_capture_pin, i_capture_pin}),
      .o_level(pins_s)
   );

   // ----------------------------------------------------------------
   // avalon-mm handshake: one wait state on every access
   // ----------------------------------------------------------------
   wire req = i_avs_read | i_avs_write;
   wire rd_take = i_avs_read & wait_q;  // read data and read side effects
   wire wr_take = i_avs_write & ~wait_q & i_avs_byteenable[0];
   wire [7:0] wd = i_avs_writedata[7:0];
   wire [5:0] adr = i_avs_address;

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         wait_q <= 1'b1;
      else
         wait_q <= ~(req & wait_q);
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   wire source_on = counter_source_sel_q != arpwm_pkg::SRC_OFF;
   // forbidden encoding 11 gives no count ticks, but unlike off it still lets a one-pulse trigger restart the counter
   wire count_tick = (counter_source_sel_q == arpwm_pkg::SRC_CPU) |
                     ((counter_source_sel_q == arpwm_pkg::SRC_LITE) & i_lite_tick);
   wire at_top = counter_q == arpwm_pkg::COUNT_TOP;
   wire overflow_evt = count_tick & at_top;
   wire cap_edge = pins_s[0] ^ cap_prev_q;
   wire lcap_edge = pins_s[1] ^ lcap_prev_q;
   // trigger edge polarity only matters while one-pulse is on
   wire op_trigger = source_on & one_pulse_enable_q & lcap_edge &
                     (pins_s[1] == one_pulse_trigger_edge_q);
   // capture only while flag is clear, so the held value is not overwritten
   wire capture_evt = cap_edge & ~capture_flag_q;

   // restart from reload, never from zero; a one-pulse trigger restarts at zero
   assign counter_d = op_trigger ? arpwm_pkg::COUNT_RESET :
                      overflow_evt ? reload_q :
                      count_tick ? 12'(counter_q + 12'h001) :
                      counter_q;

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         counter_q <= arpwm_pkg::COUNT_RESET;
         cap_prev_q <= 1'b0;
         lcap_prev_q <= 1'b0;
      end
      else
      begin
         counter_q <= counter_d;
         cap_prev_q <= pins_s[0];
         lcap_prev_q <= pins_s[1];
      end
   end

   // ----------------------------------------------------------------
   // timer control, reload and capture registers
   // ----------------------------------------------------------------
   wire rd_ctrl = rd_take & (adr == arpwm_pkg::OFF_TIMER_CTRL);
   wire rd_cap = rd_take & ((adr == arpwm_pkg::OFF_CAPTURE_HI) |
                            (adr == arpwm_pkg::OFF_CAPTURE_LO));

   // flags: hardware set wins over a clearing read in the same cycle
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         capture_flag_q <= 1'b0;
         overflow_flag_one_q <= 1'b0;
         capture_q <= arpwm_pkg::COUNT_RESET;
      end
      else
      begin
         capture_flag_q <= capture_evt | (capture_flag_q & ~rd_cap);
         overflow_flag_one_q <= overflow_evt | (overflow_flag_one_q & ~rd_ctrl);
         if (capture_evt)
            capture_q <= counter_q;
      end
   end

   // software fields; writes to the flag bits are ignored
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         capture_irq_enable_q <= 1'b0;
         counter_source_sel_q <= arpwm_pkg::SRC_OFF;
         overflow_irq_enable_one_q <= 1'b0;
         compare_irq_enable_q <= 1'b0;
         reload_q <= arpwm_pkg::COUNT_RESET;
         output_enable_q <= 4'h0;
      end
      else if (wr_take)
      begin
         if (adr == arpwm_pkg::OFF_TIMER_CTRL)
         begin
            capture_irq_enable_q <= wd[arpwm_pkg::TC_CAPTURE_IE];
            counter_source_sel_q <= wd[arpwm_pkg::TC_SOURCE_HI:arpwm_pkg::TC_SOURCE_LO];
            overflow_irq_enable_one_q <= wd[arpwm_pkg::TC_OVERFLOW_IE];
            compare_irq_enable_q <= wd[arpwm_pkg::TC_COMPARE_IE];
         end
         else if (adr == arpwm_pkg::OFF_RELOAD_HI)
            reload_q[11:8] <= wd[3:0];
         else if (adr == arpwm_pkg::OFF_RELOAD_LO)
            reload_q[7:0] <= wd;
         else if (adr == arpwm_pkg::OFF_PWM_OUT_CTRL)
            output_enable_q <= {wd[6], wd[4], wd[2], wd[0]};
      end
   end

   // ----------------------------------------------------------------
   // channels: compare flag, pwm level and invert
   // ----------------------------------------------------------------
   wire [11:0] duty [4];
   wire [3:0] cmp_hit;
   wire [3:0] pwm_raw;
   // restart of the period, by overflow or by one-pulse trigger
   wire period_start = overflow_evt | op_trigger;

   assign duty[0] = i_duty_value0;
   assign duty[1] = i_duty_value1;
   assign duty[2] = i_duty_value2;
   assign duty[3] = i_duty_value3;

   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_chan
         wire rd_chan = rd_take & is_chan(adr, g);
         wire wr_chan = wr_take & is_chan(adr, g);
         // no compare events while the counter is stopped
         assign cmp_hit[g] = count_tick & (counter_q == duty[g]);
         assign pwm_raw[g] = level_q[g] ^ channel_invert_q[g];

         always_ff @(posedge i_core_clk or posedge i_rst)
         begin
            if (i_rst)
            begin
               compare_flag_q[g] <= 1'b0;
               channel_invert_q[g] <= 1'b0;
               level_q[g] <= 1'b0;
            end
            else
            begin
               compare_flag_q[g] <= cmp_hit[g] | (compare_flag_q[g] & ~rd_chan);
               if (wr_chan)
                  channel_invert_q[g] <= wd[arpwm_pkg::CH_INVERT];
               // period start beats a coincident match
               if (period_start)
                  level_q[g] <= 1'b1;
               else if (cmp_hit[g])
                  level_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // one-pulse bits live only in channel three's register
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         one_pulse_enable_q <= 1'b0;
         one_pulse_trigger_edge_q <= 1'b0;
      end
      else if (wr_take & is_chan(adr, 3))
      begin
         one_pulse_enable_q <= wd[arpwm_pkg::CH_ONE_PULSE_EN];
         one_pulse_trigger_edge_q <= wd[arpwm_pkg::CH_ONE_PULSE_EDGE];
      end
   end

   // ----------------------------------------------------------------
   // break control
   // ----------------------------------------------------------------
   wire break_input = break1_source_sel_q ? pins_s[3] : pins_s[2];
   wire break_hit = break1_pin_enable_q & (break_input == break1_level_sel_q);
   wire wr_break = wr_take & (adr == arpwm_pkg::OFF_BREAK_CTRL);

   // the pin sets active; software may set or clear it, but the pin wins
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         break1_source_sel_q <= 1'b0;
         break1_level_sel_q <= 1'b0;
         break1_active_q <= 1'b0;
         break1_pin_enable_q <= 1'b0;
         break_pattern_q <= 4'h0;
      end
      else
      begin
         if (wr_break)
         begin
            break1_source_sel_q <= wd[arpwm_pkg::BK_SOURCE_SEL];
            break1_level_sel_q <= wd[arpwm_pkg::BK_LEVEL_SEL];
            break1_pin_enable_q <= wd[arpwm_pkg::BK_PIN_ENABLE];
            break_pattern_q <= wd[3:0];
         end
         if (break_hit)
            break1_active_q <= 1'b1;
         else if (wr_break)
            break1_active_q <= wd[arpwm_pkg::BK_ACTIVE];
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [7:0] ctrl_rd = {1'b0, capture_flag_q, capture_irq_enable_q, counter_source_sel_q,
                         overflow_flag_one_q, overflow_irq_enable_one_q, compare_irq_enable_q};
   wire [7:0] oe_rd = {1'b0, output_enable_q[3], 1'b0, output_enable_q[2],
                       1'b0, output_enable_q[1], 1'b0, output_enable_q[0]};
   wire [7:0] brk_rd = {break1_source_sel_q, break1_level_sel_q, break1_active_q,
                        break1_pin_enable_q, break_pattern_q};
   wire [3:0] op_rd = {one_pulse_enable_q, one_pulse_trigger_edge_q, 2'h0};
   wire [7:0] rd_mux;

   // unmapped offsets read as zero; reserved bits read as zero
   assign rd_mux = (adr == arpwm_pkg::OFF_TIMER_CTRL) ? ctrl_rd :
                   (adr == arpwm_pkg::OFF_COUNT_HI) ? {4'h0, counter_q[11:8]} :
                   (adr == arpwm_pkg::OFF_COUNT_LO) ? counter_q[7:0] :
                   (adr == arpwm_pkg::OFF_RELOAD_HI) ? {4'h0, reload_q[11:8]} :
                   (adr == arpwm_pkg::OFF_RELOAD_LO) ? reload_q[7:0] :
                   (adr == arpwm_pkg::OFF_PWM_OUT_CTRL) ? oe_rd :
                   is_chan(adr, 0) ? {6'h00, channel_invert_q[0], compare_flag_q[0]} :
                   is_chan(adr, 1) ? {6'h00, channel_invert_q[1], compare_flag_q[1]} :
                   is_chan(adr, 2) ? {6'h00, channel_invert_q[2], compare_flag_q[2]} :
                   is_chan(adr, 3) ? {4'h0, op_rd | {2'h0, channel_invert_q[3],
                                     compare_flag_q[3]}} :
                   (adr == arpwm_pkg::OFF_BREAK_CTRL) ? brk_rd :
                   (adr == arpwm_pkg::OFF_CAPTURE_HI) ? {4'h0, capture_q[11:8]} :
                   (adr == arpwm_pkg::OFF_CAPTURE_LO) ? capture_q[7:0] :
                   arpwm_pkg::REG_RESET;

   // read data captured on the first edge, together with read side effects
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         readdata_q <= 32'h00000000;
      else if (rd_take)
         readdata_q <= {24'h000000, rd_mux};
   end

   // ----------------------------------------------------------------
   // registered outputs: pwm pins and interrupt requests
   // ----------------------------------------------------------------
   wire [3:0] pwm_d = output_enable_q & (break1_active_q ? break_pattern_q : pwm_raw);

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pwm_q <= 4'h0;
         pwm_enable_q <= 4'h0;
         capture_irq_q <= 1'b0;
         overflow_irq_q <= 1'b0;
         compare_irq_q <= 1'b0;
      end
      else
      begin
         pwm_q <= pwm_d;
         pwm_enable_q <= output_enable_q;
         capture_irq_q <= capture_flag_q & capture_irq_enable_q;
         overflow_irq_q <= overflow_flag_one_q & overflow_irq_enable_one_q;
         compare_irq_q <= (|compare_flag_q) & compare_irq_enable_q;
      end
   end

   assign o_avs_readdata = readdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_pwm = pwm_q;
   assign o_pwm_enable = pwm_enable_q;
   assign o_capture_irq = capture_irq_q;
   assign o_overflow_irq = overflow_irq_q;
   assign o_compare_irq = compare_irq_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_ovf_set;
      @(posedge i_core_clk) disable iff (i_rst) overflow_evt |=> overflow_flag_one_q;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

   property p_reload;
      @(posedge i_core_clk) disable iff (i_rst)
         overflow_evt && !op_trigger |=> counter_q == $past(reload_q);
   endproperty
   a_reload: assert property (p_reload) else $error("counter did not reload");

   property p_count_inc;
      @(posedge i_core_clk) disable iff (i_rst)
         count_tick && !at_top && !op_trigger |=> counter_q == 12'($past(counter_q) + 12'h001);
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("counter did not step");

   property p_hold_off;
      @(posedge i_core_clk) disable iff (i_rst)
         !source_on |=> $stable(counter_q) && !($rose(overflow_flag_one_q));
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("stopped counter moved");

   property p_cap_clear;
      @(posedge i_core_clk) disable iff (i_rst) rd_cap && !capture_evt |=> !capture_flag_q;
   endproperty
   a_cap_clear: assert property (p_cap_clear) else $error("capture flag not cleared");

   property p_cap_irq;
      @(posedge i_core_clk) disable iff (i_rst)
         capture_flag_q && capture_irq_enable_q ##1 capture_flag_q |-> o_capture_irq;
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

   property p_cmp_flag;
      @(posedge i_core_clk) disable iff (i_rst) cmp_hit[0] |=> compare_flag_q[0] [*1];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

   property p_break_set;
      @(posedge i_core_clk) disable iff (i_rst) break_hit |=> break1_active_q;
   endproperty
   a_break_set: assert property (p_break_set) else $error("break not activated");

   property p_break_out;
      @(posedge i_core_clk) disable iff (i_rst)
         break1_active_q && output_enable_q[0] |=> o_pwm[0] == $past(break_pattern_q[0]);
   endproperty
   a_break_out: assert property (p_break_out) else $error("break pattern not driven");

endmodule : arpwm_timer
`default_nettype wire

// file: sim/arpwm_timer_tb_top.sv
// self-checking bench for the auto-reload pwm timer register block
`timescale 1ns/1ps
`default_nettype none
module arpwm_timer_tb_top;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic [11:0] duty0 = 12'h810;
   logic [3:0] be = 4'hF;
   logic tick = 1'b0;
   logic cap_pin = 1'b0;
   logic brk_pin = 1'b0;
   logic [3:0] pwm;
   logic [3:0] pwm_en;
   logic cap_irq;
   logic ovf_irq;
   logic cmp_irq;
   int error_cnt = 0;
   int comparisons = 0;
   // a free-running core clock; the bench never stops it
   always #10 i_core_clk = ~i_core_clk;
   arpwm_timer uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_lite_tick(tick),
      .i_duty_value0(duty0), .i_duty_value1(12'hFFF), .i_duty_value2(12'hFFF),
      .i_duty_value3(12'hFFF), .i_capture_pin(cap_pin), .i_lite_capture_pin(1'b0),
      .i_break_pin(brk_pin), .i_comparator(1'b0), .o_pwm(pwm), .o_pwm_enable(pwm_en),
      .o_capture_irq(cap_irq), .o_overflow_irq(ovf_irq), .o_compare_irq(cmp_irq));
   // ----------------------------------------------------------------
   // bus tasks and comparison
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // the request is held until waitrequest is seen low at an edge
   task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] q);
      int n;
      @(posedge i_core_clk);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wd <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 100);
      q = rdat;
      if (n >= 100) chk(1'b1, 1'b0, "bus hang");
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   // bounded wait on an interrupt line, counted as a mismatch on expiry
   task automatic wait_irq(ref logic s, input string m);
      int n;
      for (n = 0; n < 6000 && s !== 1'b1; n++) @(posedge i_core_clk);
      chk(s, 1'b1, m);
   endtask : wait_irq
   task automatic wrap_up;
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] q;
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h0, "ctrl reset");
      bus(6'h08, 1'b0, 8'h0, q); chk(q, 32'h0, "count reset");
      bus(6'h0C, 1'b0, 8'h0, q); chk(q, 32'h0, "reload reset");
      bus(6'h14, 1'b0, 8'h0, q); chk(q, 32'h0, "out ctrl reset");
      bus(6'h3C, 1'b0, 8'h0, q); chk(q, 32'h0, "unmapped read");
      // a write without byte lane 0 must be dropped
      be <= 4'hE;
      bus(6'h0C, 1'b1, 8'h05, q);
      be <= 4'hF;
      bus(6'h0C, 1'b0, 8'h0, q); chk(q, 32'h0, "lane 0 off write ignored");
   endtask : t_reset
   task automatic t_overflow;
      logic [31:0] q;
      bus(6'h0C, 1'b1, 8'h08, q);
      bus(6'h10, 1'b1, 8'h00, q);
      bus(6'h00, 1'b1, 8'h12, q);
      wait_irq(ovf_irq, "overflow irq");
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h16, "flag set");
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h12, "flag cleared by read");
      bus(6'h08, 1'b0, 8'h0, q);
      bus(6'h04, 1'b0, 8'h0, q); chk(q, 32'h08, "restart from reload");
   endtask : t_overflow
   task automatic t_compare;
      logic [31:0] q;
      // stop the counter and clear every channel flag, so the irq stays idle until a new match
      bus(6'h00, 1'b1, 8'h01, q);
      bus(6'h18, 1'b0, 8'h0, q);
      bus(6'h1C, 1'b0, 8'h0, q);
      bus(6'h20, 1'b0, 8'h0, q);
      bus(6'h24, 1'b0, 8'h0, q);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, cmp_irq}, 32'h0, "compare irq idle");
      duty0 <= 12'hF00;
      bus(6'h00, 1'b1, 8'h11, q);
      wait_irq(cmp_irq, "compare irq");
      bus(6'h18, 1'b0, 8'h0, q); chk(q, 32'h01, "compare flag");
      bus(6'h18, 1'b0, 8'h0, q); chk(q, 32'h00, "compare flag cleared");
      bus(6'h18, 1'b1, 8'h02, q);
      bus(6'h18, 1'b0, 8'h0, q); chk(q, 32'h02, "invert bit");
   endtask : t_compare
   task automatic t_hold;
      logic [31:0] a;
      logic [31:0] b;
      bus(6'h00, 1'b1, 8'h00, a);
      bus(6'h08, 1'b0, 8'h0, a);
      repeat (20) @(posedge i_core_clk);
      bus(6'h08, 1'b0, 8'h0, b); chk(b, a, "counter holds when off");
      // lite source: the counter moves only on time base ticks
      bus(6'h00, 1'b1, 8'h08, a);
      repeat (3)
      begin
         tick <= 1'b1;
         @(posedge i_core_clk);
         tick <= 1'b0;
         @(posedge i_core_clk);
      end
      bus(6'h08, 1'b0, 8'h0, a); chk(a, {24'h0, 8'(b[7:0] + 8'h03)}, "lite ticks");
   endtask : t_hold
   task automatic t_capture;
      logic [31:0] q;
      bus(6'h00, 1'b1, 8'h70, q);
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h30, "flag write ignored");
      cap_pin <= 1'b1;
      wait_irq(cap_irq, "capture irq");
      bus(6'h00, 1'b1, 8'h30, q);
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h70, "capture flag set");
      bus(6'h2C, 1'b0, 8'h0, q);
      bus(6'h00, 1'b0, 8'h0, q); chk(q, 32'h30, "capture flag cleared");
      chk({31'h0, cap_irq}, 32'h0, "capture irq off");
   endtask : t_capture
   task automatic t_break;
      logic [31:0] q;
      bus(6'h14, 1'b1, 8'h01, q);
      repeat (3) @(posedge i_core_clk);
      chk({28'h0, pwm_en}, 32'h1, "output enable");
      bus(6'h28, 1'b1, 8'h2F, q);
      repeat (3) @(posedge i_core_clk);
      chk({28'h0, pwm}, 32'h1, "break pattern high");
      bus(6'h28, 1'b1, 8'h2E, q);
      repeat (3) @(posedge i_core_clk);
      chk({28'h0, pwm}, 32'h0, "break pattern low");
      // pin armed for high level: software clears active, the pin sets it again
      bus(6'h28, 1'b1, 8'h50, q);
      bus(6'h28, 1'b0, 8'h0, q); chk(q, 32'h50, "break idle at low pin");
      brk_pin <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      bus(6'h28, 1'b0, 8'h0, q); chk(q, 32'h70, "break set by pin");
      chk({28'h0, pwm}, 32'h0, "pin break pattern");
   endtask : t_break
   // main sequence; reset is held for sixteen cycles
   initial
   begin
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_reset();
      t_overflow();
      t_compare();
      t_hold();
      t_capture();
      t_break();
      wrap_up();
   end
   // watchdog well past the few thousand cycles the scenarios need
   initial
   begin
      repeat (40000) @(posedge i_core_clk);
      error_cnt++;
      wrap_up();
   end
endmodule : arpwm_timer_tb_top
`default_nettype wire
